// ==== logic/aieb_params.svh ====
// Offsets, field positions, reset values and bus codes of the enable bank.
// Assumes inclusion by the bank package and the bank module only.
`ifndef AIEB_PARAMS_SVH
`define AIEB_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define AIEB_OFS_EN 12'h300
`define AIEB_OFS_SET 12'h304
`define AIEB_OFS_CLR 12'h308
`define AIEB_OFS_STAT 12'h310

// ==========================================================================
// Field layout and reset values
`define AIEB_EV_N 22
`define AIEB_CH_N 8
`define AIEB_BIT_CH_BASE 6
`define AIEB_EN_RESET 22'h000000
`define AIEB_STAT_RESET 22'h000000

// ==========================================================================
// Bus answer codes
`define AIEB_RESP_OKAY 2'h0
`define AIEB_RESP_SLVERR 2'h2

`endif

// ==== logic/aieb_pkg.sv ====
// Types shared by the converter interrupt enable bank.
// Assumes the constants header is on the include path.
`include "aieb_params.svh"

package aieb_pkg;

   // =======================================================================
   // Event vector, one bit per converter event.
   typedef logic [`AIEB_EV_N-1:0] aieb_evmask_type;

   // One converter result sample.
   typedef logic signed [15:0] aieb_sample_type;

   // Common event pulses; started sits in the lowest bit.
   typedef struct packed {
      logic stopped;
      logic cal_done;
      logic result_ready;
      logic done;
      logic ended;
      logic started;
   } aieb_common_type;

   // A finished conversion result with its channel.
   typedef struct packed {
      logic valid;
      logic [2:0] chan;
      aieb_sample_type value;
   } aieb_result_type;

endpackage : aieb_pkg

// ==== logic/aieb_bank.sv ====
// Interrupt enable bank for a sampling converter, with an AXI4-Lite slave.
// Assumes one clock, a synchronous active-low reset, and event pulses and
// results that are synchronous to that clock.
`timescale 1ns/100ps
`default_nettype none
`include "aieb_params.svh"

module aieb_bank
   import aieb_pkg::*;
(
   input wire logic clk, // Peripheral clock.
   input wire logic rst_b, // Synchronous reset, active low.
   input wire logic [11:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response code.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [11:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response code.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire aieb_common_type common_ev, // Common event pulses.
   input wire aieb_result_type result, // Finished conversion result.
   input wire aieb_sample_type [`AIEB_CH_N-1:0] limit_high, // High limits.
   input wire aieb_sample_type [`AIEB_CH_N-1:0] limit_low, // Low limits.
   output logic irq // Level interrupt toward the processor.
);

   // ========================================================================
   // State
   aieb_evmask_type en_q;
   aieb_evmask_type en_d;
   aieb_evmask_type stat_q;
   aieb_evmask_type stat_d;
   aieb_evmask_type event_vec;
   logic aw_held_q;
   logic w_held_q;
   logic [11:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // ========================================================================
   // Event vector: common events low, then channel pairs above them.
   assign event_vec[5:0] = common_ev;

   genvar gi;
   generate
      for (gi = 0; gi < `AIEB_CH_N; gi = gi + 1)
      begin : g_chan
         logic hit_ch;
         // A result for this channel is compared against both limits.
         assign hit_ch = result.valid && (result.chan == 3'(gi));
         assign event_vec[`AIEB_BIT_CH_BASE + 2 * gi] = hit_ch &&
            ($signed(result.value) >= $signed(limit_high[gi]));
         assign event_vec[`AIEB_BIT_CH_BASE + 2 * gi + 1] = hit_ch &&
            ($signed(result.value) <= $signed(limit_low[gi]));

         chk_high_limit_fires:
         assert property (@(posedge clk) disable iff (!rst_b)
            (hit_ch && $signed(result.value) >= $signed(limit_high[gi]))
            |=> stat_q[`AIEB_BIT_CH_BASE + 2 * gi])
         else $error("High limit event was not recorded.");

         chk_low_limit_pos:
         assert property (@(posedge clk) disable iff (!rst_b)
            (hit_ch && $signed(result.value) <= $signed(limit_low[gi]))
            |=> stat_q[`AIEB_BIT_CH_BASE + 2 * gi + 1])
         else $error("Low limit event landed in the wrong bit.");
      end
   endgenerate

   // ========================================================================
   // Write channel decode.
   logic do_wr;
   logic [31:0] wmask;
   aieb_evmask_type wbits;
   logic sel_en_w;
   logic sel_set_w;
   logic sel_clr_w;
   logic sel_stat_w;
   logic wr_hit;

   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign do_wr = aw_held_q && w_held_q;
   assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                   {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wbits = wdata_q[`AIEB_EV_N-1:0] & wmask[`AIEB_EV_N-1:0];
   assign sel_en_w = waddr_q[11:2] == `AIEB_OFS_EN >> 2;
   assign sel_set_w = waddr_q[11:2] == `AIEB_OFS_SET >> 2;
   assign sel_clr_w = waddr_q[11:2] == `AIEB_OFS_CLR >> 2;
   assign sel_stat_w = waddr_q[11:2] == `AIEB_OFS_STAT >> 2;
   assign wr_hit = sel_en_w || sel_set_w || sel_clr_w || sel_stat_w;

   // Next enable state: all three views act on the same bits.
   always_comb
   begin
      en_d = en_q;
      if (do_wr && sel_en_w)
         en_d = (en_q & ~wmask[`AIEB_EV_N-1:0]) | wbits;
      else if (do_wr && sel_set_w)
         en_d = en_q | wbits;
      else if (do_wr && sel_clr_w)
         en_d = en_q & ~wbits;
   end

   // Sticky status: an event in the clearing cycle survives the clear.
   always_comb
   begin
      stat_d = stat_q;
      if (do_wr && sel_stat_w)
         stat_d = stat_q & ~wbits;
      stat_d = stat_d | event_vec;
   end

   // Write address and data are caught separately, in either order.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         waddr_q <= 12'h000;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            waddr_q <= s_axi_awaddr;
         end
         else if (do_wr)
            aw_held_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         else if (do_wr)
            w_held_q <= 1'b0;
      end
   end

   // Write response follows the register update by no delay.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= `AIEB_RESP_OKAY;
      end
      else if (do_wr)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? `AIEB_RESP_OKAY : `AIEB_RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   // Enable and status registers.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         en_q <= `AIEB_EN_RESET;
         stat_q <= `AIEB_STAT_RESET;
      end
      else
      begin
         en_q <= en_d;
         stat_q <= stat_d;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ========================================================================
   // Read channel: one read in flight, answered the cycle after it is taken.
   logic rd_take;
   logic sel_views_r;
   logic sel_stat_r;
   logic [31:0] rd_word;

   assign s_axi_arready = !rvalid_q;
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign sel_views_r = (s_axi_araddr[11:2] == `AIEB_OFS_EN >> 2) ||
                        (s_axi_araddr[11:2] == `AIEB_OFS_SET >> 2) ||
                        (s_axi_araddr[11:2] == `AIEB_OFS_CLR >> 2);
   assign sel_stat_r = s_axi_araddr[11:2] == `AIEB_OFS_STAT >> 2;
   assign rd_word = sel_views_r ? {10'h000, en_q} :
                    sel_stat_r ? {10'h000, stat_q} : 32'h00000000;

   // Read data register.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `AIEB_RESP_OKAY;
      end
      else if (rd_take)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= (sel_views_r || sel_stat_r) ?
                    `AIEB_RESP_OKAY : `AIEB_RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ========================================================================
   // Interrupt: high while any enabled status bit is set.
   assign irq = |(stat_q & en_q);

   // ========================================================================
   // Checks
   chk_plain_view_stores:
   assert property (@(posedge clk) disable iff (!rst_b)
      (do_wr && sel_en_w) |=> (en_q == (($past(en_q) &
      ~$past(wmask[`AIEB_EV_N-1:0])) | $past(wbits))))
   else $error("Plain view write did not store the value.");

   chk_set_view_sets:
   assert property (@(posedge clk) disable iff (!rst_b)
      (do_wr && sel_set_w) |=> ((en_q & $past(wbits)) == $past(wbits)))
   else $error("Set view did not set the written ones.");

   chk_clear_view_clears:
   assert property (@(posedge clk) disable iff (!rst_b)
      (do_wr && sel_clr_w) |=> ((en_q & $past(wbits)) == 22'h000000))
   else $error("Clear view did not clear the written ones.");

   chk_zero_bits_keep:
   assert property (@(posedge clk) disable iff (!rst_b)
      (do_wr && (sel_set_w || sel_clr_w)) |=>
      ((en_q & ~$past(wbits)) == ($past(en_q) & ~$past(wbits))))
   else $error("A zero in a set or clear write changed an enable.");

   chk_read_returns_en:
   assert property (@(posedge clk) disable iff (!rst_b)
      (rd_take && sel_views_r) |=>
      (s_axi_rvalid && s_axi_rdata[`AIEB_EV_N-1:0] == $past(en_q)))
   else $error("Enable view read did not return the enables.");

   chk_upper_bits_zero:
   assert property (@(posedge clk) disable iff (!rst_b)
      s_axi_rvalid |-> (s_axi_rdata[31:`AIEB_EV_N] == 10'h000))
   else $error("Bits above the enables read nonzero.");

   chk_started_lowest:
   assert property (@(posedge clk) disable iff (!rst_b)
      common_ev.started ##1 en_q[0] |-> irq)
   else $error("Started event did not raise bit zero.");

   chk_write_answered:
   assert property (@(posedge clk) disable iff (!rst_b)
      do_wr |=> (s_axi_bvalid && !aw_held_q && !w_held_q))
   else $error("Write was not answered the next cycle.");

   chk_reset_clears_bank:
   assert property (@(posedge clk)
      !rst_b |=> (en_q == `AIEB_EN_RESET && !irq))
   else $error("Reset did not clear the enables and the interrupt.");

   chk_common_events_low:
   assert property (@(posedge clk) disable iff (!rst_b)
      (common_ev != 6'h00) |=>
      ((stat_q[5:0] & $past(common_ev)) == $past(common_ev)))
   else $error("A common event did not set its low status bit.");

endmodule : aieb_bank

`default_nettype wire

// ==== testbench/aieb_host.sv ====
// AXI4-Lite host model standing in for the processor side of the bank.
// Assumes its tasks are called from one process, just after a rising edge.
`timescale 1ns/100ps
`default_nettype none

module aieb_host
(
   input wire logic clk, // Clock.
   output logic [11:0] awaddr, // Write address.
   output logic awvalid, // Write address valid.
   input wire logic awready, // Write address ready.
   output logic [31:0] wdata, // Write data.
   output logic wvalid, // Write data valid.
   input wire logic wready, // Write data ready.
   input wire logic [1:0] bresp, // Write response.
   input wire logic bvalid, // Write response valid.
   output logic bready, // Write response ready.
   output logic [11:0] araddr, // Read address.
   output logic arvalid, // Read address valid.
   input wire logic arready, // Read address ready.
   input wire logic [31:0] rdata, // Read data.
   input wire logic [1:0] rresp, // Read response.
   input wire logic rvalid, // Read data valid.
   output logic rready // Read data ready.
);
   // ======================================================================
   // Idle bus; both answer channels are always accepted.
   initial
   begin
      {awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
      bready = 1'b1;
      rready = 1'b1;
   end

   // Offer address and data together and drop each when taken; a dropped
   // payload shows its inverse so a stale value is never mistaken.
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      output logic [1:0] r);
      logic aw_go, w_go, b_go;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      b_go = 1'b0;
      while (!b_go)
      begin
         @(negedge clk);
         aw_go = awvalid && awready;
         w_go = wvalid && wready;
         b_go = bvalid;
         r = bresp;
         @(posedge clk);
         if (aw_go)
         begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (w_go)
         begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end
   endtask

   // Offer a read address and wait for the data beat.
   task automatic rd(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
      logic ar_go, r_go;
      araddr <= a;
      arvalid <= 1'b1;
      r_go = 1'b0;
      while (!r_go)
      begin
         @(negedge clk);
         ar_go = arvalid && arready;
         r_go = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar_go)
         begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
      end
   endtask
endmodule // aieb_host

`default_nettype wire

// ==== testbench/tb_adc_interrupt_enable_bank.sv ====
// Self-checking bench for the converter interrupt enable bank.
// Assumes the package and the host model are compiled before it.
`timescale 1ns/100ps
`default_nettype none

module tb_adc_interrupt_enable_bank
   import aieb_pkg::*;
;
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } aieb_row_type;

   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, got;
   logic [1:0] bresp, rresp, resp;
   logic [3:0] wstrb = 4'hF;
   aieb_common_type common_ev = '0;
   aieb_result_type result = '0;
   aieb_sample_type [7:0] limit_high = {8{16'h0064}};
   aieb_sample_type [7:0] limit_low = {8{16'hFF9C}};
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   // Write a view, then every view must read back the shared enables.
   aieb_row_type rows [8] = '{
      '{12'h300, 32'hFFFFFFFF, 32'h003FFFFF},
      '{12'h300, 32'h00000000, 32'h00000000},
      '{12'h304, 32'h00000005, 32'h00000005},
      '{12'h304, 32'h00000000, 32'h00000005},
      '{12'h308, 32'h00000001, 32'h00000004},
      '{12'h308, 32'h00000000, 32'h00000004},
      '{12'h304, 32'hFFC00000, 32'h00000004},
      '{12'h300, 32'h00200000, 32'h00200000}};

   // ======================================================================
   // Clock of 4 ns.
   initial
      forever #2 clk = ~clk;

   aieb_bank DUT
   (
      .clk, .rst_b,
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .common_ev, .result, .limit_high, .limit_low, .irq
   );

   aieb_host host
   (
      .clk, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready
   );

   // Compare one value and count it.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Read a register and compare its data.
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      host.rd(a, got, resp);
      chk(got, e);
   endtask

   // Enable only mask e, pulse one event, check irq and the status bits.
   task automatic fire(input aieb_common_type c, input aieb_result_type r,
      input logic [31:0] e);
      host.wr(12'h300, e, resp);
      host.wr(12'h310, 32'hFFFFFFFF, resp);
      common_ev <= c;
      result <= r;
      @(posedge clk);
      common_ev <= '0;
      result <= '0;
      @(negedge clk);
      chk({31'h0, irq}, {31'h0, |e});
      @(posedge clk);
      rd_chk(12'h310, e);
   endtask

   // Print the counts and the verdict, then stop.
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Cut a hung run short.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_count++;
         wrap_up();
      end
   end

   // ======================================================================
   // Main sequence.
   initial
   begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd_chk(12'h300, 32'h0);
      foreach (rows[i])
      begin
         host.wr(rows[i].a, rows[i].d, resp);
         chk({30'h0, resp}, 32'h0);
         for (int v = 0; v < 3; v++)
            rd_chk(12'h300 + 12'(4 * v), rows[i].e);
         chk({30'h0, resp}, 32'h0);
      end
      // Unmapped place is refused and leaves the enables alone.
      host.wr(12'h30C, 32'hFFFFFFFF, resp);
      chk({30'h0, resp}, 32'h2);
      rd_chk(12'h300, 32'h00200000);
      rd_chk(12'h30C, 32'h0);
      chk({30'h0, resp}, 32'h2);
      // Only the strobed byte lane of a plain write lands.
      wstrb <= 4'h1;
      host.wr(12'h300, 32'h003FFFFF, resp);
      wstrb <= 4'hF;
      rd_chk(12'h300, 32'h002000FF);
      for (int i = 0; i < 6; i++)
         fire(aieb_common_type'(6'(1 << i)), '0, 32'(1) << i);
      for (int n = 0; n < 8; n++)
      begin
         fire('0, {1'b1, 3'(n), 16'h0064}, 32'(1) << (6 + 2 * n));
         fire('0, {1'b1, 3'(n), 16'hFF9C}, 32'(1) << (7 + 2 * n));
         fire('0, {1'b1, 3'(n), 16'h0063}, 32'h0);
      end
      // Each channel compares against its own high limit.
      limit_high[3] <= 16'h0070;
      fire('0, {1'b1, 3'h3, 16'h0064}, 32'h0);
      fire('0, {1'b1, 3'h3, 16'h0070}, 32'h00001000);
      // Clearing the enable drops irq while the status bit stays.
      fire('0, {1'b1, 3'h7, 16'h0064}, 32'h00100000);
      host.wr(12'h308, 32'h00100000, resp);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      @(posedge clk);
      rd_chk(12'h310, 32'h00100000);
      // A reset in mid-run clears the enables, the status and the line.
      host.wr(12'h304, 32'h00100003, resp);
      @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      @(posedge clk);
      rd_chk(12'h304, 32'h0);
      rd_chk(12'h310, 32'h0);
      wrap_up();
   end
endmodule // tb_adc_interrupt_enable_bank

`default_nettype wire
